// [hw/sstp_cfg.svh]
// Purpose: constants of the sync status and time code panel
// Assumes: 10 MHz system clock
// Notes: included by the panel module and the testbench
`ifndef SSTP_CFG_SVH
`define SSTP_CFG_SVH

`define SSTP_CLK_HZ 10000000
// flash half periods in milliseconds
`define SSTP_FAST_HALF_MS 125
`define SSTP_SLOW_HALF_MS 500
`define SSTP_FAST_HALF_CYC ((`SSTP_FAST_HALF_MS * (`SSTP_CLK_HZ / 1000)))
`define SSTP_SLOW_HALF_CYC ((`SSTP_SLOW_HALF_MS * (`SSTP_CLK_HZ / 1000)))

// register byte addresses
`define SSTP_ADDR_CTRL 8'h00
`define SSTP_ADDR_EXPECT 8'h04
`define SSTP_ADDR_STATUS 8'h08
`define SSTP_ADDR_PERIOD 8'h0C

// control field positions
`define SSTP_CTRL_SRC_LSB 0
`define SSTP_CTRL_RATE_LSB 2
`define SSTP_CTRL_DROP 5
`define SSTP_CTRL_REMOTE 6
`define SSTP_CTRL_IDLEMUTE 7
`define SSTP_CTRL_WC256 8
`define SSTP_CTRL_GENRUN 9

// reset values
`define SSTP_EXPECT_RST 20'h00000
`define SSTP_RATE_RST 3'h0
`define SSTP_SRC_RST 2'h0

// deviation limits: 0.025 % is 1/4000, 4 % is 1/25
`define SSTP_FINE_DIV 32'h00000FA0
`define SSTP_COARSE_DIV 32'h00000019

// word clock divider: tick runs at 512x sample rate
`define SSTP_WC_DIV_W 9
`endif

// [hw/sstp_pkg.sv]
// Purpose: types of the sync status and time code panel
// Assumes: constants come from sstp_cfg.svh
// Notes: none
package sstp_pkg;
    typedef enum logic [1:0] {SRC_LTC = 2'h0, SRC_VITC = 2'h1, SRC_AUTO = 2'h2,
        SRC_GEN = 2'h3} sstp_src_t;
    typedef enum logic [2:0] {FR_30 = 3'h0, FR_2997 = 3'h1, FR_25 = 3'h2, FR_24 = 3'h3,
        FR_23976 = 3'h4} sstp_rate_t;
    typedef enum logic [4:0] {CLS_SOLID = 5'b00001, CLS_YFAST = 5'b00010,
        CLS_YSLOW = 5'b00100, CLS_RFAST = 5'b01000, CLS_RSLOW = 5'b10000} sstp_cls_t;

    typedef struct packed {
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
        logic [7:0] frames;
    } sstp_tc_t;

    typedef struct packed {
        sstp_tc_t tc;
        logic dpFrames;
        logic dpMinutes;
    } sstp_disp_t;

    typedef struct packed {
        logic led30;
        logic led2997;
        logic led25;
        logic led24;
        logic dropFrameIndicator;
        logic ltcLed;
        logic vitcLed;
        logic lockGreen;
        logic lockYellow;
        logic rateYellow;
        logic rateRed;
        logic remoteLed;
    } sstp_leds_t;

    typedef struct packed {
        sstp_src_t src;
        sstp_rate_t rate;
        logic dropFrame;
        logic remote;
        logic idleMute;
        logic wc256;
        logic genRun;
        logic [19:0] expPeriod;
        logic [19:0] perCnt;
        logic [19:0] perMeas;
        sstp_cls_t cls;
        logic [23:0] fastCnt;
        logic [23:0] slowCnt;
        logic fastPh;
        logic slowPh;
        logic [8:0] wcDiv;
        logic wcOut;
        logic aesFrame;
        logic [31:0] rdata;
        sstp_disp_t disp;
        logic [7:0] mtcData;
        logic mtcValid;
    } sstp_state_t;
endpackage

// [hw/sstp_panel.sv]
// Purpose: front panel status, time code display and clock output logic
// Assumes: inputs synchronous to clk; one-cycle tick pulses
// Notes: AES output content is silence; incoming AES content has no port
//
// How it works
// - show current reference as hh:mm:ss:ff
// - frames point lit on even field
// - parity only from VITC below half speed
// - minutes point lit in auto source mode
// - display raw incoming code, no offset
// - auto: both lit deciding, then chosen one
// - four rate LEDs plus drop-frame indicator
// - 23.976 flashes the 24 LED
// - lock LED solid green when locked
// - unlocked flashes yellow (HD) or green
// - within 0.025 percent: solid yellow
// - 0.025 to 4 percent: yellow fast/slow
// - beyond 4 percent: red fast/slow
// - rate LED dark when not locked
// - remote mode lights LED, ignores switches
// - MIDI output carries time code only
// - generate mode MTC follows run/stop
// - MTC continuous, muted on idle LTC
// - AES out all zero at sample rate
// - AES input content never forwarded
// - word clock 1x or 256x selectable
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "sstp_cfg.svh"

module sstp_panel import sstp_pkg::*; #(
    parameter int unsigned FAST_HALF_CYC = `SSTP_FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF_CYC = `SSTP_SLOW_HALF_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire sstp_tc_t incomingTc,
    input wire sstp_tc_t generatorTc,
    input wire logic fieldEven,
    input wire logic vitcSlow,
    input wire logic autoDecided,
    input wire logic autoPickVitc,
    input wire logic locked,
    input wire logic hdVariant,
    input wire logic refTick,
    input wire logic [3:0] panelSw,
    input wire logic ltcIdle,
    input wire logic [7:0] mtcInData,
    input wire logic mtcInValid,
    input wire logic mtcInIsTc,
    input wire logic wcTick,
    output sstp_disp_t disp,
    output sstp_leds_t leds,
    output logic [7:0] mtcData,
    output logic mtcValid,
    output logic [23:0] aesSample,
    output logic aesFrame,
    output logic wcOut
);
    sstp_state_t s_q;
    sstp_state_t s_d;
    logic [19:0] meas;
    logic [19:0] dev;
    logic [31:0] dev32;
    logic [31:0] exp32;
    logic refSlow;
    logic vitcActive;
    logic swAct;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        swAct = !s_q.remote && (panelSw != 4'h0);
        // register writes win over panel switches
        if (wr && addr == `SSTP_ADDR_CTRL) begin
            s_d.src = sstp_src_t'(wdata[`SSTP_CTRL_SRC_LSB +: 2]);
            s_d.rate = sstp_rate_t'(wdata[`SSTP_CTRL_RATE_LSB +: 3]);
            s_d.dropFrame = wdata[`SSTP_CTRL_DROP];
            s_d.remote = wdata[`SSTP_CTRL_REMOTE];
            s_d.idleMute = wdata[`SSTP_CTRL_IDLEMUTE];
            s_d.wc256 = wdata[`SSTP_CTRL_WC256];
            s_d.genRun = wdata[`SSTP_CTRL_GENRUN];
        end else if (swAct) begin
            if (panelSw[0]) begin
                s_d.rate = (s_q.rate == FR_23976) ? FR_30 : sstp_rate_t'(s_q.rate + 3'h1);
            end
            if (panelSw[1]) begin
                s_d.src = sstp_src_t'(s_q.src + 2'h1);
            end
            if (panelSw[2]) begin
                s_d.genRun = !s_q.genRun;
            end
            if (panelSw[3]) begin
                s_d.dropFrame = !s_q.dropFrame;
            end
        end
        if (wr && addr == `SSTP_ADDR_EXPECT) begin
            s_d.expPeriod = wdata[19:0];
        end

        // flash timebases shared by every flashing LED
        s_d.fastCnt = s_q.fastCnt + 24'h000001;
        if (s_q.fastCnt == 24'(FAST_HALF_CYC - 1)) begin
            s_d.fastCnt = 24'h000000;
            s_d.fastPh = !s_q.fastPh;
        end
        s_d.slowCnt = s_q.slowCnt + 24'h000001;
        if (s_q.slowCnt == 24'(SLOW_HALF_CYC - 1)) begin
            s_d.slowCnt = 24'h000000;
            s_d.slowPh = !s_q.slowPh;
        end

        // period measurement, one window per reference tick
        meas = s_q.perCnt + 20'h00001;
        refSlow = meas > s_q.expPeriod;
        dev = refSlow ? (meas - s_q.expPeriod) : (s_q.expPeriod - meas);
        dev32 = {12'h000, dev};
        exp32 = {12'h000, s_q.expPeriod};
        if (refTick) begin
            s_d.perCnt = 20'h00000;
            s_d.perMeas = meas;
            if (dev32 * `SSTP_FINE_DIV <= exp32) begin
                s_d.cls = CLS_SOLID;
            end else if (dev32 * `SSTP_COARSE_DIV <= exp32) begin
                s_d.cls = refSlow ? CLS_YSLOW : CLS_YFAST;
            end else begin
                s_d.cls = refSlow ? CLS_RSLOW : CLS_RFAST;
            end
        end else if (s_q.perCnt != 20'hFFFFF) begin
            s_d.perCnt = meas;
        end

        // display
        vitcActive = (s_q.src == SRC_VITC) || (s_q.src == SRC_AUTO && autoDecided
            && autoPickVitc);
        s_d.disp.tc = (s_q.src == SRC_GEN) ? generatorTc : incomingTc;
        s_d.disp.dpFrames = vitcActive && vitcSlow && fieldEven;
        s_d.disp.dpMinutes = (s_q.src == SRC_AUTO);

        // MTC gating: only time code messages pass
        s_d.mtcData = mtcInData;
        s_d.mtcValid = mtcInValid && mtcInIsTc
            && (s_q.src != SRC_GEN || s_q.genRun)
            && !(s_q.idleMute && ltcIdle);

        // word clock and silent AES frame strobe
        s_d.aesFrame = 1'b0;
        if (wcTick) begin
            s_d.wcDiv = s_q.wcDiv + 9'h001;
            s_d.aesFrame = (s_q.wcDiv == 9'h1FF);
        end
        s_d.wcOut = s_q.wc256 ? s_q.wcDiv[0] : s_q.wcDiv[8];

        // register read data, one cycle after the strobe
        s_d.rdata = 32'h00000000;
        if (rd) begin
            unique case (addr)
                `SSTP_ADDR_CTRL: s_d.rdata = {22'h000000, s_q.genRun, s_q.wc256,
                    s_q.idleMute, s_q.remote, s_q.dropFrame, s_q.rate, s_q.src};
                `SSTP_ADDR_EXPECT: s_d.rdata = {12'h000, s_q.expPeriod};
                `SSTP_ADDR_STATUS: s_d.rdata = {24'h000000, hdVariant, locked,
                    autoDecided, s_q.cls};
                `SSTP_ADDR_PERIOD: s_d.rdata = {12'h000, s_q.perMeas};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.src <= sstp_src_t'(`SSTP_SRC_RST);
            s_q.rate <= sstp_rate_t'(`SSTP_RATE_RST);
            s_q.expPeriod <= `SSTP_EXPECT_RST;
            s_q.cls <= CLS_SOLID;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rdata = s_q.rdata;
    assign disp = s_q.disp;
    assign mtcData = s_q.mtcData;
    assign mtcValid = s_q.mtcValid;
    // incoming AES audio has no path here, so silence cannot be broken
    assign aesSample = 24'h000000;
    assign aesFrame = s_q.aesFrame;
    assign wcOut = s_q.wcOut;

    always_comb begin
        leds.led30 = (s_q.rate == FR_30);
        leds.led2997 = (s_q.rate == FR_2997);
        leds.led25 = (s_q.rate == FR_25);
        leds.led24 = (s_q.rate == FR_24) || (s_q.rate == FR_23976 && s_q.slowPh);
        leds.dropFrameIndicator = s_q.dropFrame;
        // both source LEDs stay lit until the auto choice settles
        leds.ltcLed = (s_q.src == SRC_LTC) || (s_q.src == SRC_AUTO
            && (!autoDecided || !autoPickVitc));
        leds.vitcLed = (s_q.src == SRC_VITC) || (s_q.src == SRC_AUTO
            && (!autoDecided || autoPickVitc));
        leds.lockGreen = locked || (!hdVariant && s_q.slowPh);
        leds.lockYellow = !locked && hdVariant && s_q.slowPh;
        leds.rateYellow = 1'b0;
        leds.rateRed = 1'b0;
        if (locked) begin
            unique case (s_q.cls)
                CLS_SOLID: leds.rateYellow = 1'b1;
                CLS_YFAST: leds.rateYellow = s_q.fastPh;
                CLS_YSLOW: leds.rateYellow = s_q.slowPh;
                CLS_RFAST: leds.rateRed = s_q.fastPh;
                CLS_RSLOW: leds.rateRed = s_q.slowPh;
            endcase
        end
        leds.remoteLed = s_q.remote;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence wcFullCycle;
        wcTick && s_q.wcDiv == 9'h1FF ##1 aesFrame;
    endsequence

    AST_DISP_SOURCE: assert property (@(posedge clk) disable iff (reset)
        s_q.src != SRC_GEN |=> disp.tc == $past(incomingTc))
        else $error("display does not follow incoming time code");
    AST_PARITY_VITC: assert property (@(posedge clk) disable iff (reset)
        disp.dpFrames |-> $past(vitcSlow) && $past(fieldEven) && $past(s_q.src) != SRC_LTC)
        else $error("field parity shown outside slow VITC");
    AST_DP_MINUTES: assert property (@(posedge clk) disable iff (reset)
        s_q.src == SRC_AUTO |=> disp.dpMinutes)
        else $error("minutes point dark in auto mode");
    AST_AUTO_BOTH: assert property (@(posedge clk) disable iff (reset)
        s_q.src == SRC_AUTO && !autoDecided |-> leds.ltcLed && leds.vitcLed)
        else $error("source LEDs not both lit while deciding");
    AST_RATE_24: assert property (@(posedge clk) disable iff (reset)
        s_q.rate == FR_23976 && $rose(s_q.slowPh) && !wr |-> leds.led24 ##1 leds.led24)
        else $error("24 LED not flashing for 23.976");
    AST_LOCK: assert property (@(posedge clk) disable iff (reset)
        locked |-> leds.lockGreen && !leds.lockYellow)
        else $error("lock LED not solid green when locked");
    AST_RATE_DARK: assert property (@(posedge clk) disable iff (reset)
        !locked |-> !leds.rateYellow && !leds.rateRed)
        else $error("rate LED lit while unlocked");
    AST_REMOTE: assert property (@(posedge clk) disable iff (reset)
        s_q.remote && panelSw != 4'h0 && !wr |=> $stable(s_q.rate) && $stable(s_q.src))
        else $error("panel switch acted in remote mode");
    AST_MTC_MUTE: assert property (@(posedge clk) disable iff (reset)
        s_q.idleMute && ltcIdle |=> !mtcValid)
        else $error("MTC sent while LTC idle and muted");
    AST_MTC_ONLY: assert property (@(posedge clk) disable iff (reset)
        !mtcInIsTc |=> !mtcValid)
        else $error("non time code MIDI forwarded");
    AST_AES_RATE: assert property (@(posedge clk) disable iff (reset)
        aesFrame |-> $past(wcTick) && $past(s_q.wcDiv) == 9'h1FF)
        else $error("AES frame off the sample clock");
    AST_WC_FRAME: assert property (@(posedge clk) disable iff (reset)
        wcFullCycle |-> s_q.wcDiv == 9'h000)
        else $error("word clock divider did not wrap");
    AST_CLASS_WINDOW: assert property (@(posedge clk) disable iff (reset)
        !refTick |=> $stable(s_q.cls))
        else $error("deviation class changed inside a window");

    // ----------------------------------------------------------------
    // checks of display, indicators, MTC, period window and clock outputs
    // ----------------------------------------------------------------
    sequence fastWrap;
        s_q.fastCnt == 24'(FAST_HALF_CYC - 1) ##1 s_q.fastCnt == 24'h000000;
    endsequence
    sequence slowWrap;
        s_q.slowCnt == 24'(SLOW_HALF_CYC - 1) ##1 s_q.slowCnt == 24'h000000;
    endsequence

    AST_GEN_TC: assert property (@(posedge clk) disable iff (reset)
        s_q.src == SRC_GEN |=> disp.tc == $past(generatorTc))
        else $error("display does not follow generator time code");
    AST_PARITY_ODD: assert property (@(posedge clk) disable iff (reset)
        !fieldEven |=> !disp.dpFrames)
        else $error("frames point lit on odd field");
    AST_AUTO_CHOSEN: assert property (@(posedge clk) disable iff (reset)
        s_q.src == SRC_AUTO && autoDecided |-> leds.vitcLed == autoPickVitc && leds.ltcLed == !autoPickVitc)
        else $error("source LEDs do not show the chosen source");
    AST_RATE_ONEHOT: assert property (@(posedge clk) disable iff (reset)
        $onehot0({leds.led30, leds.led2997, leds.led25, leds.led24}))
        else $error("more than one frame rate LED lit");
    AST_RATE_24_DARK: assert property (@(posedge clk) disable iff (reset)
        s_q.rate == FR_23976 && !s_q.slowPh |-> !leds.led24)
        else $error("24 LED steady for 23.976");
    AST_UNLOCK_HD: assert property (@(posedge clk) disable iff (reset)
        !locked && hdVariant |-> !leds.lockGreen && leds.lockYellow == s_q.slowPh)
        else $error("unlocked HD lock LED not flashing yellow");
    AST_UNLOCK_SD: assert property (@(posedge clk) disable iff (reset)
        !locked && !hdVariant |-> !leds.lockYellow && leds.lockGreen == s_q.slowPh)
        else $error("unlocked lock LED not flashing green");
    AST_RATE_SOLID: assert property (@(posedge clk) disable iff (reset)
        locked && s_q.cls == CLS_SOLID |-> leds.rateYellow && !leds.rateRed)
        else $error("rate LED not solid yellow");
    AST_RATE_YFAST: assert property (@(posedge clk) disable iff (reset)
        locked && s_q.cls == CLS_YFAST |-> leds.rateYellow == s_q.fastPh && !leds.rateRed)
        else $error("rate LED not fast yellow");
    AST_RATE_YSLOW: assert property (@(posedge clk) disable iff (reset)
        locked && s_q.cls == CLS_YSLOW |-> leds.rateYellow == s_q.slowPh && !leds.rateRed)
        else $error("rate LED not slow yellow");
    AST_RATE_RFAST: assert property (@(posedge clk) disable iff (reset)
        locked && s_q.cls == CLS_RFAST |-> leds.rateRed == s_q.fastPh && !leds.rateYellow)
        else $error("rate LED not fast red");
    AST_RATE_RSLOW: assert property (@(posedge clk) disable iff (reset)
        locked && s_q.cls == CLS_RSLOW |-> leds.rateRed == s_q.slowPh && !leds.rateYellow)
        else $error("rate LED not slow red");
    AST_GEN_STOP: assert property (@(posedge clk) disable iff (reset)
        s_q.src == SRC_GEN && !s_q.genRun |=> !mtcValid)
        else $error("MTC sent while generator stopped");
    AST_MTC_DATA: assert property (@(posedge clk) disable iff (reset)
        mtcValid |-> mtcData == $past(mtcInData))
        else $error("MTC byte altered on its way out");
    AST_WC_1X: assert property (@(posedge clk) disable iff (reset)
        !s_q.wc256 |=> wcOut == $past(s_q.wcDiv[8]))
        else $error("word clock not at 1x");
    AST_WC_256X: assert property (@(posedge clk) disable iff (reset)
        s_q.wc256 |=> wcOut == $past(s_q.wcDiv[0]))
        else $error("word clock not at 256x");
    AST_FAST_FLASH: assert property (@(posedge clk) disable iff (reset)
        fastWrap |-> $changed(s_q.fastPh))
        else $error("fast flash phase did not turn");
    AST_SLOW_FLASH: assert property (@(posedge clk) disable iff (reset)
        slowWrap |-> $changed(s_q.slowPh))
        else $error("slow flash phase did not turn");
    AST_PERIOD_RESTART: assert property (@(posedge clk) disable iff (reset)
        refTick |=> s_q.perCnt == 20'h00000 && s_q.perMeas == $past(s_q.perCnt) + 20'h00001)
        else $error("window did not restart at reference tick");
endmodule // sstp_panel

// [test/sstp_ref_src.sv]
// Purpose: far-side reference and word clock tick source
// Assumes: period of at least 2 cycles
// Notes: reference runs free, as a house clock does
`timescale 1ns/100ps

module sstp_ref_src (
    input wire logic clk,
    input wire logic reset,
    input wire logic [19:0] period,
    output logic refTick,
    output logic wcTick
);
    logic [19:0] cnt_q;
    // host side drives no deck-control port here, so never two at once
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 20'h00000;
            refTick <= 1'b0;
            wcTick <= 1'b0;
        end else begin
            refTick <= (cnt_q == period - 20'h00001);
            cnt_q <= (cnt_q >= period - 20'h00001) ? 20'h00000 : cnt_q + 20'h00001;
            // tick every other cycle so wcTick stays a pulse
            wcTick <= ~wcTick;
        end
    end
endmodule // sstp_ref_src

// [test/tb.sv]
// Purpose: self-checking bench of the panel
// Assumes: flash half periods cut to 4 and 16 cycles
// Notes: reads and time code bytes are scored from queues
`timescale 1ns/100ps
`include "sstp_cfg.svh"

module tb import sstp_pkg::*; ;
    logic clk, reset, mtcValid, aesFrame, wcOut, refTick, wcTick;
    logic wr = 1'b0, rd = 1'b0, fieldEven = 1'b0, vitcSlow = 1'b0, autoDecided = 1'b0;
    logic autoPickVitc = 1'b0, locked = 1'b0, hdVariant = 1'b0, ltcIdle = 1'b0;
    logic mtcInValid = 1'b0, mtcInIsTc = 1'b0, rdPend = 1'b0;
    logic [7:0] addr = 8'h00, mtcInData = 8'h00, mtcData;
    logic [31:0] wdata = 32'h0, rdata, rnd = 32'h66ED;
    logic [3:0] panelSw = 4'h0;
    logic [19:0] period = 20'h003E8;
    logic [19:0] per[5] = '{20'h003E8, 20'h003DE, 20'h003F2, 20'h00384, 20'h0044C};
    logic [23:0] aesSample;
    sstp_tc_t incomingTc = '0, generatorTc = '0;
    sstp_disp_t disp;
    sstp_leds_t leds;
    logic [13:0] mon;
    int miscompares = 0, comparisons = 0, ones[14], rises[14];
    logic [31:0] rdq[$], mkq[$];
    logic [7:0] mtq[$];
    assign mon = {leds, aesFrame, wcOut};

    sstp_panel #(.FAST_HALF_CYC(4), .SLOW_HALF_CYC(16)) dut (.clk(clk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .incomingTc(incomingTc),
        .generatorTc(generatorTc), .fieldEven(fieldEven), .vitcSlow(vitcSlow),
        .autoDecided(autoDecided), .autoPickVitc(autoPickVitc), .locked(locked),
        .hdVariant(hdVariant), .refTick(refTick), .panelSw(panelSw), .ltcIdle(ltcIdle),
        .mtcInData(mtcInData), .mtcInValid(mtcInValid), .mtcInIsTc(mtcInIsTc),
        .wcTick(wcTick), .disp(disp), .leds(leds), .mtcData(mtcData), .mtcValid(mtcValid),
        .aesSample(aesSample), .aesFrame(aesFrame), .wcOut(wcOut));
    sstp_ref_src ref_src (.clk(clk), .reset(reset), .period(period), .refTick(refTick),
        .wcTick(wcTick));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rdq.push_back(e);
        mkq.push_back(m);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic mtc(input logic isTc, input logic pass);
        rnd = xs(rnd);
        @(posedge clk);
        mtcInData <= rnd[7:0];
        mtcInValid <= 1'b1;
        mtcInIsTc <= isTc;
        if (pass)
            mtq.push_back(rnd[7:0]);
        @(posedge clk);
        mtcInValid <= 1'b0;
    endtask
    task automatic press(input logic [3:0] v);
        @(posedge clk);
        panelSw <= v;
        @(posedge clk);
        panelSw <= 4'h0;
    endtask
    // counts level and rising edges of every watched output
    task automatic watch(input int n);
        logic [13:0] prev;
        @(negedge clk);
        prev = mon;
        ones = '{default: 0};
        rises = '{default: 0};
        repeat (n) begin
            @(negedge clk);
            for (int i = 0; i < 14; i++) begin
                ones[i] += mon[i];
                rises[i] += mon[i] & ~prev[i];
            end
            prev = mon;
        end
    endtask
    task automatic waitRef(input int n);
        int k;
        k = 0;
        while (n > 0) begin
            @(posedge clk);
            if (refTick === 1'b1)
                n--;
            if (++k > 5000) begin
                miscompares++;
                end_of_test();
            end
        end
    endtask

    // ------------------------------
    // scoreboard of reads and bytes
    // ------------------------------
    always @(posedge clk) begin
        if (rdPend === 1'b1) begin
            check("rdata", rdata & mkq[0], rdq[0] & mkq[0]);
            void'(rdq.pop_front());
            void'(mkq.pop_front());
        end
        if (mtcValid === 1'b1) begin
            if (mtq.size() == 0)
                check("mtcExtra", 32'h1, 32'h0);
            else
                check("mtcData", mtcData, mtq.pop_front());
        end
        if (reset === 1'b0)
            check("aesSample", aesSample, 32'h0);
        rdPend <= rd;
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #9000000;
        miscompares++;
        end_of_test();
    end

    initial begin
        reset = 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rreg(`SSTP_ADDR_CTRL, 32'h0, 32'hFFFFFFFF);
        rreg(`SSTP_ADDR_STATUS, 32'h1, 32'h1F);
        rreg(8'h10, 32'h0, 32'hFFFFFFFF);
        rnd = xs(rnd);
        incomingTc <= rnd;
        generatorTc <= ~rnd;
        fieldEven <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            wreg(`SSTP_ADDR_CTRL, i >> 2);
            vitcSlow <= i[0];
            autoPickVitc <= i[0];
            autoDecided <= i[1];
            repeat (2) @(posedge clk);
            @(negedge clk);
            check("dispTc", disp.tc, rnd);
            check("dpF", disp.dpFrames, i[0] & (i[3:2] == 1 | i[3:2] == 2 & i[1]));
            check("dpM", disp.dpMinutes, i[3:2] == 2);
            check("srcLeds", {leds.ltcLed, leds.vitcLed}, i[3:2] == 0 ? 2'h2 : i[3:2] == 1 ?
                2'h1 : !i[1] ? 2'h3 : i[0] ? 2'h1 : 2'h2);
        end
        wreg(`SSTP_ADDR_CTRL, 32'h3);
        fieldEven <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("genTc", disp.tc, ~rnd);
        for (int r = 0; r < 5; r++) begin
            wreg(`SSTP_ADDR_CTRL, (r << 2) | (r[0] << 5));
            watch(64);
            check("led30", ones[13], (r == 0) * 64);
            check("led2997", ones[12], (r == 1) * 64);
            check("led25", ones[11], (r == 2) * 64);
            check("led24", ones[10] == 64, r == 3);
            check("dropFrame", ones[9], r[0] * 64);
        end
        check("led24Flash", rises[10] >= 1 && ones[10] < 64, 1'b1);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            locked <= (k == 0);
            hdVariant <= (k == 1);
            watch(64);
            check("lockG", k == 2 ? rises[6] > 0 : ones[6] == 64 * (k == 0), 1'b1);
            check("lockY", k == 1 ? rises[5] > 0 : ones[5] == 0, 1'b1);
            if (k > 0)
                check("rateDark", ones[4] + ones[3], 32'h0);
        end
        @(posedge clk);
        locked <= 1'b1;
        wreg(`SSTP_ADDR_EXPECT, 32'h3E8);
        for (int c = 0; c < 5; c++) begin
            @(posedge clk);
            period <= per[c];
            waitRef(3);
            rreg(`SSTP_ADDR_STATUS, 32'h1 << c, 32'h1F);
            rreg(`SSTP_ADDR_PERIOD, per[c], 32'hFFFFF);
            watch(64);
            check("rateY", c == 0 ? ones[4] == 64 : c > 2 ? ones[4] == 0 : rises[4] > 0,
                1'b1);
            check("rateR", c > 2 ? rises[3] > 0 : ones[3] == 0, 1'b1);
            check("fast", rises[c > 2 ? 3 : 4] >= 6, c == 1 || c == 3);
        end
        wreg(`SSTP_ADDR_CTRL, 32'h40);
        press(4'hF);
        @(negedge clk);
        check("remoteLed", leds.remoteLed, 1'b1);
        rreg(`SSTP_ADDR_CTRL, 32'h40, 32'h3FF);
        wreg(`SSTP_ADDR_CTRL, 32'h0);
        press(4'h1);
        rreg(`SSTP_ADDR_CTRL, 32'h4, 32'h1C);
        mtc(1'b0, 1'b0);
        mtc(1'b1, 1'b1);
        wreg(`SSTP_ADDR_CTRL, 32'h3);
        mtc(1'b1, 1'b0);
        wreg(`SSTP_ADDR_CTRL, 32'h203);
        mtc(1'b1, 1'b1);
        wreg(`SSTP_ADDR_CTRL, 32'h80);
        ltcIdle <= 1'b1;
        mtc(1'b1, 1'b0);
        ltcIdle <= 1'b0;
        mtc(1'b1, 1'b1);
        for (int w = 0; w < 2; w++) begin
            wreg(`SSTP_ADDR_CTRL, w << 8);
            @(posedge clk);
            watch(2048);
            check("aesFrame", ones[1], 32'h2);
            check("wcRises", rises[0], w ? 512 : 2);
        end
        check("mtcLeft", mtq.size(), 32'h0);
        end_of_test();
    end
endmodule // tb
